// ==== testbench/bus_master_model.sv ====
// Behavioural two-wire bus master that drives SCL and pulls SDA low.
// Assumes a pull-up resolves SDA outside and feeds the level to sda_i.
module bus_master_model #(
  parameter int HALF = 10,
  parameter int LAG = 5
) (
  // Clock
  input wire logic mclk_i,
  // Bus
  input wire logic sda_i,
  output logic scl_o,
  output logic sda_low_o
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    scl_o = 1'b1;
    sda_low_o = 1'b0;
  end

  task automatic wait_cyc(input int n);
    repeat (n) @(posedge mclk_i);
  endtask : wait_cyc

  // SDA only moves LAG cycles after SCL fell, so the slave's synchroniser
  // never sees a data change while SCL is still high.
  task automatic bit_cycle(input logic low, output logic got);
    sda_low_o <= low;
    wait_cyc(HALF);
    scl_o <= 1'b1;
    wait_cyc(HALF);
    got = sda_i;
    scl_o <= 1'b0;
    wait_cyc(LAG);
  endtask : bit_cycle

  task automatic start_cond();
    sda_low_o <= 1'b0;
    wait_cyc(HALF);
    scl_o <= 1'b1;
    wait_cyc(HALF);
    sda_low_o <= 1'b1;
    wait_cyc(HALF);
    scl_o <= 1'b0;
    wait_cyc(LAG);
  endtask : start_cond

  task automatic stop_cond();
    sda_low_o <= 1'b1;
    wait_cyc(HALF);
    scl_o <= 1'b1;
    wait_cyc(HALF);
    sda_low_o <= 1'b0;
    wait_cyc(HALF);
  endtask : stop_cond

  task automatic send_byte(input rtc_pkg::byte_t b, output logic ack);
    logic got;
    for (int i = 7; i >= 0; i--) begin
      bit_cycle(!b[i], got);
    end
    bit_cycle(1'b0, got);
    ack = !got;
  endtask : send_byte

  task automatic recv_byte(input logic give_ack, output rtc_pkg::byte_t b);
    logic got;
    for (int i = 7; i >= 0; i--) begin
      bit_cycle(1'b0, got);
      b[i] = got;
    end
    bit_cycle(give_ack, got);
  endtask : recv_byte
endmodule : bus_master_model

// ==== testbench/testbench.sv ====
// Self-checking bench of the serial slave port against a memory model.
// Assumes the port and the bus master model are compiled before it.
`include "rtc_regs.svh"
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int REC = 16;
  localparam int POR = 4;
  localparam int TICK_SPAN = 1100;
  localparam rtc_pkg::byte_t WR_ADDR = {`RTC_SLAVE_ADDR, 1'b0};
  localparam rtc_pkg::byte_t RD_ADDR = {`RTC_SLAVE_ADDR, 1'b1};

  logic mclk = 1'b0;
  logic arst_n = 1'b0;
  logic osc_tick = 1'b0;
  logic pf_sense = 1'b0;
  logic rst_req = 1'b0;
  logic tick_all = 1'b0;
  wire logic scl;
  wire logic sda_low;
  wire logic sda_o;
  wire logic sda_oe;
  wire logic pf_flag;
  wire logic rst_out;
  wire logic sda;
  int mem[64];
  int ptr = 0;
  int num_errors = 0;
  int checks = 0;
  integer seed = 32'h993A;
  logic ack;

  // SDA has a pull-up: it is low only while some party pulls it.
  assign sda = !(sda_low || (sda_oe && !sda_o));

  always #20 mclk = ~mclk;

  // Oscillator ticks arrive at random, or on every cycle while tick_all is
  // set; that starves the write buffer, so no byte is written then. Time
  // runs from reset until the first write stops it, and is stopped outside the timekeeping scenario after that.
  always @(posedge mclk) begin
    osc_tick <= tick_all || (($random(seed) & 31) == 0);
  end

  rtc_serial_slave_port #(
    .REC_CYCLES(REC),
    .POR_CYCLES(POR),
    .FIFO_DEPTH(16)
  ) rtc_serial_slave_port_i (
    .mclk_i(mclk),
    .arst_n_i(arst_n),
    .scl_i(scl),
    .sda_i(sda),
    .sda_o(sda_o),
    .sda_oe_o(sda_oe),
    .osc_tick_i(osc_tick),
    .power_fail_sense_in_i(pf_sense),
    .reset_request_in_i(rst_req),
    .power_fail_flag_out_o(pf_flag),
    .reset_o(rst_out)
  );

  bus_master_model #(
    .HALF(10),
    .LAG(5)
  ) bus_master_model_i (
    .mclk_i(mclk),
    .sda_i(sda),
    .scl_o(scl),
    .sda_low_o(sda_low)
  );

  task automatic close_out();
    $display("errors %0d checks %0d", num_errors, checks);
    if (num_errors == 0 && checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : close_out

  task automatic chk_bit(input logic got, input logic exp, input string what);
    checks++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED t=%0t %s got %b exp %b", $time, what, got, exp);
    end
  endtask : chk_bit

  task automatic chk_byte(input rtc_pkg::byte_t got, input rtc_pkg::byte_t exp);
    checks++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED t=%0t read byte %h exp %h", $time, got, exp);
    end
  endtask : chk_byte

  task automatic wait_rst_low(input int limit);
    int n;
    n = 0;
    while (rst_out !== 1'b0 && n < limit) begin
      @(posedge mclk);
      n++;
    end
    chk_bit(rst_out, 1'b0, "reset output release");
  endtask : wait_rst_low

  // Model: a write to a clock byte clears the hundredths byte.
  task automatic model_write(input int val);
    if (ptr < `RTC_CLK_LOCS) begin
      mem[0] = 0;
    end
    mem[ptr] = (ptr == 0) ? 0 : val;
    ptr = (ptr + 1) % 64;
  endtask : model_write

  task automatic set_ptr(input int at);
    bus_master_model_i.start_cond();
    bus_master_model_i.send_byte(WR_ADDR, ack);
    chk_bit(ack, 1'b1, "address ack");
    bus_master_model_i.send_byte(8'(at), ack);
    chk_bit(ack, 1'b1, "word ack");
    ptr = at;
  endtask : set_ptr

  task automatic wr_seq(input int at, input int n, input int fixed);
    rtc_pkg::byte_t val;
    set_ptr(at);
    for (int i = 0; i < n; i++) begin
      val = (fixed >= 0) ? 8'(fixed) : 8'($random(seed));
      bus_master_model_i.send_byte(val, ack);
      chk_bit(ack, 1'b1, "data ack");
      model_write(int'(val));
    end
    bus_master_model_i.stop_cond();
  endtask : wr_seq

  task automatic rd_seq(input logic set, input int at, input int n);
    rtc_pkg::byte_t got;
    if (set) begin
      set_ptr(at);
    end
    bus_master_model_i.start_cond();
    bus_master_model_i.send_byte(RD_ADDR, ack);
    chk_bit(ack, 1'b1, "read address ack");
    for (int i = 0; i < n; i++) begin
      bus_master_model_i.recv_byte(i != n - 1, got);
      chk_byte(got, 8'(mem[ptr]));
      if (i != n - 1) begin
        ptr = (ptr + 1) % 64;
      end
    end
    chk_bit(sda_oe, 1'b0, "sda released after last byte");
    bus_master_model_i.stop_cond();
  endtask : rd_seq

  initial begin
    repeat (60000) @(posedge mclk);
    num_errors++;
    close_out();
  end

  initial begin
    repeat (5) @(posedge mclk);
    chk_bit(rst_out, 1'b1, "reset output in reset");
    chk_bit(sda_oe, 1'b0, "sda idle in reset");
    arst_n <= 1'b1;
    wait_rst_low(POR + 20);
    bus_master_model_i.start_cond();
    bus_master_model_i.send_byte(8'hA0, ack);
    chk_bit(ack, 1'b0, "foreign address ack");
    bus_master_model_i.stop_cond();
    wr_seq(1, 1, 8'h80);
    wr_seq(62, 3, -1);
    rd_seq(1'b1, 62, 3);
    rd_seq(1'b0, 0, 1);
    wr_seq(20, 24, -1);
    rd_seq(1'b1, 20, 24);
    // Restart time, count a span of three whole hundredths,
    // read the hundredths byte, then stop time again.
    wr_seq(1, 1, 0);
    tick_all <= 1'b1;
    repeat (TICK_SPAN) @(posedge mclk);
    tick_all <= 1'b0;
    mem[0] = (TICK_SPAN * 100) / 32768;
    rd_seq(1'b1, 0, 1);
    wr_seq(1, 1, 8'h80);
    set_ptr(32);
    pf_sense <= 1'b1;
    repeat (3) @(posedge mclk);
    chk_bit(pf_flag, 1'b1, "power fail flag");
    chk_bit(rst_out, 1'b1, "reset output in power fail");
    bus_master_model_i.send_byte(8'h5A, ack);
    chk_bit(ack, 1'b0, "ack while power failed");
    bus_master_model_i.stop_cond();
    bus_master_model_i.start_cond();
    bus_master_model_i.send_byte(WR_ADDR, ack);
    chk_bit(ack, 1'b0, "address ack while power failed");
    bus_master_model_i.stop_cond();
    pf_sense <= 1'b0;
    ptr = 0;
    repeat (8) @(posedge mclk);
    chk_bit(rst_out, 1'b1, "protection during recovery");
    wait_rst_low(REC + 20);
    rd_seq(1'b0, 0, 1);
    rd_seq(1'b1, 32, 2);
    rst_req <= 1'b1;
    repeat (3) @(posedge mclk);
    chk_bit(rst_out, 1'b1, "reset output on request");
    rst_req <= 1'b0;
    wait_rst_low(POR + 20);
    close_out();
  end
endmodule : testbench

// ==== verilog/byte_fifo.sv ====
// Synchronous flip-flop FIFO with valid/ready on both sides.
// Assumes one clock and an asynchronous active-low reset.
module byte_fifo #(
  parameter int W = 14,
  parameter int DEPTH = 16
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic arst_n_i,
  // Streams
  stream_if.snk wr,
  stream_if.src rd
);
  localparam int AW = $clog2(DEPTH);

  logic [W-1:0] store [DEPTH];
  logic [AW:0] wptr;
  logic [AW:0] rptr;
  wire full = (wptr[AW] != rptr[AW]) && (wptr[AW-1:0] == rptr[AW-1:0]);
  wire empty = (wptr == rptr);
  wire push = wr.valid && !full;
  wire pop = rd.ready && !empty;

  assign wr.ready = !full;
  assign rd.valid = !empty;
  assign rd.data = store[rptr[AW-1:0]];

  always_ff @(posedge clk_i) begin
    if (push) begin
      store[wptr[AW-1:0]] <= wr.data;
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      wptr <= '0;
      rptr <= '0;
    end else begin
      if (push) begin
        wptr <= wptr + 1'b1;
      end
      if (pop) begin
        rptr <= rptr + 1'b1;
      end
    end
  end
endmodule : byte_fifo

// ==== verilog/rtc_pkg.sv ====
// Types shared by the RTC serial port and its testbench.
// Assumes nothing beyond a SystemVerilog compiler.
package rtc_pkg;

  typedef logic [7:0] byte_t;

  typedef enum logic [3:0] {
    ST_IDLE,
    ST_ADDR,
    ST_ACK_ADDR,
    ST_WORD,
    ST_ACK_DATA,
    ST_WDATA,
    ST_RDATA,
    ST_RACK
  } port_state_t;

endpackage : rtc_pkg

// ==== verilog/rtc_regs.svh ====
// Offsets, field positions, reset values and timing counts of the RTC port.
// Assumes it is included by bare name wherever these constants are used.
`ifndef RTC_REGS_SVH
`define RTC_REGS_SVH

// Seven-bit bus address; the address byte on the wire reads 8'hD0.
`define RTC_SLAVE_ADDR 7'h68
`define RTC_MEM_DEPTH 64
`define RTC_PTR_W 6
`define RTC_CLK_LOCS 8
// Location map, zero based.
`define RTC_LOC_HUND 6'h00
`define RTC_LOC_CTRL 6'h08
`define RTC_LOC_WDOG 6'h09
`define RTC_LOC_ALARM 6'h0A
`define RTC_LOC_RSVD 6'h10
`define RTC_LOC_SQUARE 6'h13
`define RTC_LOC_USER 6'h14
// Clock field positions.
`define RTC_HALT_BIT 7
`define RTC_CENT_EN_BIT 7
`define RTC_CENT_FLIP_BIT 6
// Timebase and timing.
`define RTC_OSC_HZ 17'h08000
`define RTC_HUND_STEP 17'h00064
`define RTC_CLK_MHZ 25
`define RTC_REC_TIME_US 1000
`define RTC_REC_CYCLES (`RTC_REC_TIME_US * `RTC_CLK_MHZ)
`define RTC_POR_TIME_US 100
`define RTC_POR_CYCLES (`RTC_POR_TIME_US * `RTC_CLK_MHZ)
`define RTC_FIFO_DEPTH 16
`define RTC_BYTE_RESET 8'h00

`endif

// ==== verilog/rtc_serial_slave_port.sv ====
// Two-wire slave port of a 64-byte timekeeping memory with calendar.
// Assumes SCL/SDA arrive as plain levels, osc_tick_i pulses once per
// oscillator cycle and power_fail_sense_in_i is high below the threshold.
`include "rtc_regs.svh"

// Notes on behaviour
// - Sixty-four byte storage array reached over the serial port.
// - Pointer advances by one after each data byte written or acknowledged on read.
// - START then address byte; answer only the fixed address.
// - Locations map clock, control, watchdog, alarm, reserved, square, user.
// - Clock bytes hold BCD time, century bit, 24-hour form.
// - Month lengths 28 to 31, leap years correct through 2099.
// - Time counts from the 32.768 kHz oscillator tick.
// - Power fail aborts access and clears the pointer.
// - Bus inputs ignored while power has failed.
// - Write protection holds a recovery interval after power returns.
// - Reset output follows power-on detection and the reset request.
// - Bus idle when both lines high.
// - SDA steady while SCL high; a change is a condition.
// - SDA falling while SCL high is START.
// - SDA rising while SCL high is STOP.
// - One SCL pulse per bit; SDA changes only while SCL low.
// - Any number of bytes between START and STOP.
// - Eight-bit bytes, each followed by an acknowledge bit.
// - Acknowledger holds SDA low through the acknowledge high phase.
// - Master withholds last acknowledge; device then releases SDA.
// - Device acknowledges every byte it receives while the write buffer has room.
// - First written byte after address loads the pointer.
// - Reads advance the pointer only on the master acknowledge clock.
// - Read without pointer write starts at the held pointer.
// - Clock copies freeze while clock locations are accessed.
module rtc_serial_slave_port #(
  parameter int REC_CYCLES = `RTC_REC_CYCLES,
  parameter int POR_CYCLES = `RTC_POR_CYCLES,
  parameter int FIFO_DEPTH = `RTC_FIFO_DEPTH
) (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic arst_n_i,
  // Serial bus
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_o,
  // Timebase
  input wire logic osc_tick_i,
  // Supervisory
  input wire logic power_fail_sense_in_i,
  input wire logic reset_request_in_i,
  output logic power_fail_flag_out_o,
  output logic reset_o
);
  localparam int PW = `RTC_PTR_W;

  // ****************************************
  // Synchronisers and bus conditions
  // ****************************************
  logic [1:0] scl_sync;
  logic [1:0] sda_sync;
  logic scl_q;
  logic sda_q;
  logic protect;

  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      scl_sync <= 2'h3;
      sda_sync <= 2'h3;
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_sync <= {scl_sync[0], scl_i};
      sda_sync <= {sda_sync[0], sda_i};
      scl_q <= scl_sync[1];
      sda_q <= sda_sync[1];
    end
  end

  // Protection masks every bus event, so nothing reaches memory.
  // The raw sense input masks too, so a byte ending in the very cycle
  // that power fails is not pushed before protection is registered.
  wire bus_on = !protect && !power_fail_sense_in_i;
  wire scl_s = scl_sync[1];
  wire sda_s = sda_sync[1];
  wire scl_rise = bus_on && scl_s && !scl_q;
  wire scl_fall = bus_on && !scl_s && scl_q;
  wire start_det = bus_on && scl_s && scl_q && sda_q && !sda_s;
  wire stop_det = bus_on && scl_s && scl_q && !sda_q && sda_s;

  // ****************************************
  // Supervisor
  // ****************************************
  localparam int REC_W = $clog2(REC_CYCLES + 1);
  localparam int POR_W = $clog2(POR_CYCLES + 1);
  logic [REC_W-1:0] rec_cnt;
  logic [POR_W-1:0] por_cnt;
  wire pf = power_fail_sense_in_i;
  wire rec_busy = (rec_cnt != '0);

  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      protect <= 1'b1;
      rec_cnt <= '0;
      por_cnt <= POR_W'(POR_CYCLES);
      power_fail_flag_out_o <= 1'b0;
      reset_o <= 1'b1;
    end else begin
      if (pf) begin
        rec_cnt <= REC_W'(REC_CYCLES);
      end else if (rec_busy) begin
        rec_cnt <= rec_cnt - 1'b1;
      end
      protect <= pf || rec_busy || (por_cnt != '0);
      if (por_cnt != '0) begin
        por_cnt <= por_cnt - 1'b1;
      end
      power_fail_flag_out_o <= pf;
      reset_o <= (por_cnt != '0) || reset_request_in_i || pf
        || rec_busy;
    end
  end

  // ****************************************
  // Byte engine
  // ****************************************
  rtc_pkg::port_state_t state;
  logic [3:0] bit_cnt;
  logic [7:0] shift_in;
  logic [7:0] shift_out;
  logic [PW-1:0] ptr;
  logic rw;
  logic master_ack;
  logic [7:0] mem [`RTC_MEM_DEPTH];
  stream_if #(.W(PW+8)) push_s ();
  stream_if #(.W(PW+8)) drain_s ();

  wire byte_end = scl_fall && (bit_cnt == 4'h8);
  wire addr_hit = (shift_in[7:1] == `RTC_SLAVE_ADDR);
  wire rd_next = (state == rtc_pkg::ST_RACK) && scl_fall && master_ack;
  wire [7:0] rd_byte = mem[ptr];
  wire wr_byte = (state == rtc_pkg::ST_WDATA) && byte_end;

  assign push_s.valid = wr_byte && push_s.ready;
  assign push_s.data = {ptr, shift_in};

  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      state <= rtc_pkg::ST_IDLE;
      bit_cnt <= 4'h0;
      shift_in <= 8'h00;
      shift_out <= 8'h00;
      ptr <= '0;
      rw <= 1'b0;
      master_ack <= 1'b0;
      sda_oe_o <= 1'b0;
      sda_o <= 1'b0;
    end else if (pf) begin
      state <= rtc_pkg::ST_IDLE;
      ptr <= '0;
      sda_oe_o <= 1'b0;
      bit_cnt <= 4'h0;
    end else if (stop_det) begin
      state <= rtc_pkg::ST_IDLE;
      sda_oe_o <= 1'b0;
    end else if (start_det) begin
      state <= rtc_pkg::ST_ADDR;
      bit_cnt <= 4'h0;
      sda_oe_o <= 1'b0;
    end else if (scl_rise) begin
      bit_cnt <= bit_cnt + 4'h1;
      shift_in <= {shift_in[6:0], sda_s};
      if (state == rtc_pkg::ST_RACK) begin
        master_ack <= !sda_s;
        if (!sda_s) begin
          ptr <= ptr + 1'b1;
        end
      end
    end else if (scl_fall) begin
      case (state)
        rtc_pkg::ST_ADDR: begin
          if (byte_end) begin
            state <= addr_hit ? rtc_pkg::ST_ACK_ADDR : rtc_pkg::ST_IDLE;
            sda_oe_o <= addr_hit;
            rw <= shift_in[0];
          end
        end
        rtc_pkg::ST_ACK_ADDR: begin
          bit_cnt <= 4'h0;
          if (rw) begin
            state <= rtc_pkg::ST_RDATA;
            shift_out <= {rd_byte[6:0], 1'b1};
            sda_oe_o <= !rd_byte[7];
          end else begin
            state <= rtc_pkg::ST_WORD;
            sda_oe_o <= 1'b0;
          end
        end
        rtc_pkg::ST_WORD: begin
          if (byte_end) begin
            ptr <= shift_in[PW-1:0];
            sda_oe_o <= 1'b1;
            state <= rtc_pkg::ST_ACK_DATA;
          end
        end
        rtc_pkg::ST_ACK_DATA: begin
          sda_oe_o <= 1'b0;
          bit_cnt <= 4'h0;
          state <= rtc_pkg::ST_WDATA;
        end
        rtc_pkg::ST_WDATA: begin
          if (byte_end) begin
            // A full buffer refuses the byte with a missing acknowledge.
            sda_oe_o <= push_s.ready;
            ptr <= push_s.ready ? ptr + 1'b1 : ptr;
            state <= push_s.ready ? rtc_pkg::ST_ACK_DATA
                                  : rtc_pkg::ST_IDLE;
          end
        end
        rtc_pkg::ST_RDATA: begin
          if (byte_end) begin
            sda_oe_o <= 1'b0;
            state <= rtc_pkg::ST_RACK;
          end else begin
            sda_oe_o <= !shift_out[7];
            shift_out <= {shift_out[6:0], 1'b1};
          end
        end
        rtc_pkg::ST_RACK: begin
          bit_cnt <= 4'h0;
          if (rd_next) begin
            state <= rtc_pkg::ST_RDATA;
            shift_out <= {rd_byte[6:0], 1'b1};
            sda_oe_o <= !rd_byte[7];
          end else begin
            state <= rtc_pkg::ST_IDLE;
            sda_oe_o <= 1'b0;
          end
        end
        default: begin
          sda_oe_o <= 1'b0;
        end
      endcase
    end
  end

  // ****************************************
  // Write buffer
  // ****************************************
  // The buffer drains on every cycle without an oscillator step, so a
  // clock write never collides with a counting step.
  assign drain_s.ready = !osc_tick_i;

  byte_fifo #(.W(PW+8), .DEPTH(FIFO_DEPTH)) u_wbuf (
    .clk_i(mclk_i),
    .arst_n_i(arst_n_i),
    .wr(push_s),
    .rd(drain_s)
  );

  wire drain = drain_s.valid && drain_s.ready;
  wire [PW-1:0] wr_loc = drain_s.data[PW+7:8];
  wire [7:0] wr_val = drain_s.data[7:0];
  wire wr_clk = drain && (wr_loc < PW'(`RTC_CLK_LOCS));

  // ****************************************
  // Timekeeping
  // ****************************************
  logic [7:0][7:0] tk;
  logic [7:0][7:0] next_tk;
  logic [16:0] acc;

  function automatic logic [7:0] bcd_inc(input logic [7:0] v);
    bcd_inc = (v[3:0] == 4'h9) ? {v[7:4] + 4'h1, 4'h0}
                               : {v[7:4], v[3:0] + 4'h1};
  endfunction : bcd_inc

  function automatic logic [5:0] month_days(input logic [4:0] mon,
                                            input logic [7:0] yr);
    logic leap;
    leap = yr[4] ? (yr[3:0] == 4'h2 || yr[3:0] == 4'h6)
                 : (yr[3:0] == 4'h0 || yr[3:0] == 4'h4 || yr[3:0] == 4'h8);
    case (mon)
      5'h02: month_days = leap ? 6'h29 : 6'h28;
      5'h04, 5'h06, 5'h09, 5'h11: month_days = 6'h30;
      default: month_days = 6'h31;
    endcase
  endfunction : month_days

  wire [16:0] acc_sum = acc + `RTC_HUND_STEP;
  wire run = osc_tick_i && !tk[1][`RTC_HALT_BIT];
  wire hund_step = run && (acc_sum >= `RTC_OSC_HZ);
  wire c_hs = hund_step && (tk[0] == 8'h99);
  wire c_s = c_hs && (tk[1][6:0] == 7'h59);
  wire c_m = c_s && (tk[2][6:0] == 7'h59);
  wire c_h = c_m && (tk[3][5:0] == 6'h23);
  wire c_d = c_h && (tk[5][5:0] == month_days(tk[6][4:0], tk[7]));
  wire c_mo = c_d && (tk[6][4:0] == 5'h12);
  wire c_y = c_mo && (tk[7] == 8'h99);
  wire [7:0] inc_sec = bcd_inc(tk[1]);
  wire [7:0] inc_min = bcd_inc(tk[2]);
  wire [7:0] inc_hour = bcd_inc(tk[3]);
  wire [7:0] inc_date = bcd_inc(tk[5]);
  wire [7:0] inc_mon = bcd_inc(tk[6]);

  always_comb begin
    next_tk = tk;
    if (wr_clk) begin
      next_tk[wr_loc[2:0]] = wr_val;
      next_tk[0] = `RTC_BYTE_RESET;
    end else begin
      if (hund_step) next_tk[0] = c_hs ? 8'h00 : bcd_inc(tk[0]);
      if (c_hs) next_tk[1][6:0] = c_s ? 7'h00 : inc_sec[6:0];
      if (c_s) next_tk[2][6:0] = c_m ? 7'h00 : inc_min[6:0];
      if (c_m) next_tk[3][5:0] = c_h ? 6'h00 : inc_hour[5:0];
      if (c_h) next_tk[4][2:0] = (tk[4][2:0] == 3'h7) ? 3'h1
                                  : tk[4][2:0] + 3'h1;
      if (c_h) next_tk[5][5:0] = c_d ? 6'h01 : inc_date[5:0];
      if (c_d) next_tk[6][4:0] = c_mo ? 5'h01 : inc_mon[4:0];
      if (c_mo) next_tk[7] = c_y ? 8'h00 : bcd_inc(tk[7]);
      if (c_y && tk[3][`RTC_CENT_EN_BIT]) begin
        next_tk[3][`RTC_CENT_FLIP_BIT] = !tk[3][`RTC_CENT_FLIP_BIT];
      end
    end
  end

  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      tk <= '0;
      acc <= 17'h00000;
    end else begin
      tk <= next_tk;
      if (wr_clk) begin
        acc <= 17'h00000;
      end else if (run) begin
        acc <= hund_step ? acc_sum - `RTC_OSC_HZ : acc_sum;
      end
    end
  end

  // ****************************************
  // Storage array
  // ****************************************
  // Copies stop while the master sits on a clock location, so a
  // multi-byte time read never tears across a rollover.
  wire freeze = (state != rtc_pkg::ST_IDLE)
             && (ptr < PW'(`RTC_CLK_LOCS));

  for (genvar i = 0; i < `RTC_MEM_DEPTH; i++) begin : g_mem
    always_ff @(posedge mclk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
        mem[i] <= `RTC_BYTE_RESET;
      end else if (i < `RTC_CLK_LOCS) begin
        if (!freeze) begin
          mem[i] <= tk[i % `RTC_CLK_LOCS];
        end
      end else if (drain && (wr_loc == PW'(i))) begin
        mem[i] <= wr_val;
      end
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  sequence s_wbyte_taken;
    wr_byte && push_s.ready && !pf && !stop_det && !start_det;
  endsequence

  sequence s_master_ack;
    (state == rtc_pkg::ST_RACK) && scl_rise && !sda_s && !pf
      && !stop_det;
  endsequence

  property p_pf_abort;
    @(posedge mclk_i) disable iff (!arst_n_i)
    pf |=> (state == rtc_pkg::ST_IDLE) && (ptr == '0) && !sda_oe_o;
  endproperty
  a_pf_abort: assert property (p_pf_abort)
    else $error("power fail did not abort the access");

  property p_pf_ignore;
    @(posedge mclk_i) disable iff (!arst_n_i)
    protect |=> !sda_oe_o && (state == rtc_pkg::ST_IDLE);
  endproperty
  a_pf_ignore: assert property (p_pf_ignore)
    else $error("bus acted on while protected");

  property p_recovery;
    @(posedge mclk_i) disable iff (!arst_n_i)
    $fell(pf) |=> protect [*8];
  endproperty
  a_recovery: assert property (p_recovery)
    else $error("protection dropped before recovery ended");

  property p_reset_req;
    @(posedge mclk_i) disable iff (!arst_n_i)
    reset_request_in_i |=> reset_o;
  endproperty
  a_reset_req: assert property (p_reset_req)
    else $error("reset output missed the reset request");

  property p_start;
    @(posedge mclk_i) disable iff (!arst_n_i)
    start_det && !pf && !stop_det |=> state == rtc_pkg::ST_ADDR;
  endproperty
  a_start: assert property (p_start)
    else $error("start condition not taken");

  property p_stop;
    @(posedge mclk_i) disable iff (!arst_n_i)
    stop_det |=> (state == rtc_pkg::ST_IDLE) && !sda_oe_o;
  endproperty
  a_stop: assert property (p_stop)
    else $error("stop condition not taken");

  property p_wr_ack;
    @(posedge mclk_i) disable iff (!arst_n_i)
    s_wbyte_taken |=> sda_oe_o && (ptr == PW'($past(ptr) + 1'b1));
  endproperty
  a_wr_ack: assert property (p_wr_ack)
    else $error("received byte not acknowledged");

  property p_ptr_load;
    @(posedge mclk_i) disable iff (!arst_n_i)
    (state == rtc_pkg::ST_WORD) && byte_end && !pf && !stop_det
      && !start_det |=> ptr == $past(shift_in[PW-1:0]);
  endproperty
  a_ptr_load: assert property (p_ptr_load)
    else $error("pointer not loaded from word byte");

  property p_rd_adv;
    @(posedge mclk_i) disable iff (!arst_n_i)
    s_master_ack |=> ptr == PW'($past(ptr) + 1'b1);
  endproperty
  a_rd_adv: assert property (p_rd_adv)
    else $error("read pointer did not step on acknowledge");

  property p_freeze;
    @(posedge mclk_i) disable iff (!arst_n_i)
    freeze |=> $stable(mem[1]) && $stable(mem[0]);
  endproperty
  a_freeze: assert property (p_freeze)
    else $error("clock copy changed while frozen");

  property p_idle_release;
    @(posedge mclk_i) disable iff (!arst_n_i)
    state == rtc_pkg::ST_IDLE |-> !sda_oe_o;
  endproperty
  a_idle_release: assert property (p_idle_release)
    else $error("SDA driven on an idle bus");
endmodule : rtc_serial_slave_port

// ==== verilog/stream_if.sv ====
// Valid/ready stream carrier between the port and its write buffer.
// Assumes both ends share one clock.
interface stream_if #(
  parameter int W = 14
);
  logic valid;
  logic ready;
  logic [W-1:0] data;

  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface : stream_if
